/* core/rbt_top.sv */
// Registered bus transceiver: two 8-bit slices with storage registers
//
// Summary of operation
// - Two identical independently controlled 8-bit slices, usable together as 16 bits.
// - Rising a_capture_clk stores A port; rising b_capture_clk stores B port.
// - Capture happens on every rising edge regardless of enable or direction.
// - drive_enable_n high isolates both ports; registers hold without edges.
// - Isolated slice still stores A, B, or both in one cycle.
// - Enabled, flow B-to-A, live select: A driven with live B.
// - Enabled, flow B-to-A, stored select: A driven with B register.
// - Enabled, flow A-to-B, live select: B driven with live A.
// - Enabled, flow A-to-B, stored select: B driven with A register.
// - Never both ports of one slice driven; flow select alone picks the driven port.
// - In transceive mode the input port value may enter either register.
// - Switching live/stored source causes no glitch on the driven port.
`timescale 1ns/10ps
`include "rbt_cfg.svh"
module rbt_top #(
  parameter int SLICE_W = `RBT_SLICE_W,
  parameter int SLICES = `RBT_SLICES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Per-slice controls (pins)
  input wire logic [SLICES-1:0] drive_enable_n,
  input wire logic [SLICES-1:0] a_to_b_flow_sel,
  input wire logic [SLICES-1:0] a_out_source_sel,
  input wire logic [SLICES-1:0] b_out_source_sel,
  input wire logic [SLICES-1:0] a_capture_clk,
  input wire logic [SLICES-1:0] b_capture_clk,
  // A port
  input wire logic [SLICES*SLICE_W-1:0] a_port_bits_i,
  output logic [SLICES*SLICE_W-1:0] a_port_bits_o,
  output logic [SLICES*SLICE_W-1:0] a_port_bits_oe,
  // B port
  input wire logic [SLICES*SLICE_W-1:0] b_port_bits_i,
  output logic [SLICES*SLICE_W-1:0] b_port_bits_o,
  output logic [SLICES*SLICE_W-1:0] b_port_bits_oe,
  // Capture log stream
  output logic log_valid,
  input wire logic log_ready,
  output logic [2*SLICES+2*SLICES*SLICE_W-1:0] log_data,
  output logic log_space,
  output logic log_overrun_q
);

  localparam int W = SLICES * SLICE_W;
  localparam int LOG_W = 2 * SLICES + 2 * W;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [W-1:0] a_in_s1_q;
  logic [W-1:0] a_in_s2_q;
  logic [W-1:0] b_in_s1_q;
  logic [W-1:0] b_in_s2_q;
  logic [SLICES-1:0] den_s1_q;
  logic [SLICES-1:0] den_s2_q;
  logic [SLICES-1:0] dir_s1_q;
  logic [SLICES-1:0] dir_s2_q;
  logic [SLICES-1:0] asel_s1_q;
  logic [SLICES-1:0] asel_s2_q;
  logic [SLICES-1:0] bsel_s1_q;
  logic [SLICES-1:0] bsel_s2_q;
  logic [SLICES-1:0] aclk_s1_q;
  logic [SLICES-1:0] aclk_s2_q;
  logic [SLICES-1:0] aclk_s3_q;
  logic [SLICES-1:0] bclk_s1_q;
  logic [SLICES-1:0] bclk_s2_q;
  logic [SLICES-1:0] bclk_s3_q;

  // Data and capture clocks pass the same two stages, so they stay aligned
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      a_in_s1_q <= '0;
      a_in_s2_q <= '0;
      b_in_s1_q <= '0;
      b_in_s2_q <= '0;
    end else begin
      a_in_s1_q <= a_port_bits_i;
      a_in_s2_q <= a_in_s1_q;
      b_in_s1_q <= b_port_bits_i;
      b_in_s2_q <= b_in_s1_q;
    end
  end

  // Enables come up inactive so the ports start isolated
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      den_s1_q <= {SLICES{`RBT_DRIVE_EN_N_RST}};
      den_s2_q <= {SLICES{`RBT_DRIVE_EN_N_RST}};
      dir_s1_q <= {SLICES{`RBT_CTRL_RST}};
      dir_s2_q <= {SLICES{`RBT_CTRL_RST}};
      asel_s1_q <= {SLICES{`RBT_CTRL_RST}};
      asel_s2_q <= {SLICES{`RBT_CTRL_RST}};
      bsel_s1_q <= {SLICES{`RBT_CTRL_RST}};
      bsel_s2_q <= {SLICES{`RBT_CTRL_RST}};
    end else begin
      den_s1_q <= drive_enable_n;
      den_s2_q <= den_s1_q;
      dir_s1_q <= a_to_b_flow_sel;
      dir_s2_q <= dir_s1_q;
      asel_s1_q <= a_out_source_sel;
      asel_s2_q <= asel_s1_q;
      bsel_s1_q <= b_out_source_sel;
      bsel_s2_q <= bsel_s1_q;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      aclk_s1_q <= '0;
      aclk_s2_q <= '0;
      aclk_s3_q <= '0;
      bclk_s1_q <= '0;
      bclk_s2_q <= '0;
      bclk_s3_q <= '0;
    end else begin
      aclk_s1_q <= a_capture_clk;
      aclk_s2_q <= aclk_s1_q;
      aclk_s3_q <= aclk_s2_q;
      bclk_s1_q <= b_capture_clk;
      bclk_s2_q <= bclk_s1_q;
      bclk_s3_q <= bclk_s2_q;
    end
  end

  // ----------------------------------------------------------------
  // Capture edges and storage
  // ----------------------------------------------------------------
  logic [SLICES-1:0] a_rise;
  logic [SLICES-1:0] b_rise;
  logic [W-1:0] a_store_q;
  logic [W-1:0] b_store_q;

  assign a_rise = aclk_s2_q & ~aclk_s3_q;
  assign b_rise = bclk_s2_q & ~bclk_s3_q;

  always_ff @(posedge clk) begin
    for (int s = 0; s < SLICES; s++) begin
      if (a_rise[s]) begin
        a_store_q[s*SLICE_W +: SLICE_W] <= a_in_s2_q[s*SLICE_W +: SLICE_W];
      end
      if (b_rise[s]) begin
        b_store_q[s*SLICE_W +: SLICE_W] <= b_in_s2_q[s*SLICE_W +: SLICE_W];
      end
    end
  end

  // ----------------------------------------------------------------
  // Output steering
  // ----------------------------------------------------------------
  // Flow select alone picks port
  function automatic rbt_pkg::rbt_mode_e mode_of(input logic den_n, input logic a_to_b);
    if (den_n) begin
      mode_of = rbt_pkg::RBT_ISOLATE;
    end else if (a_to_b) begin
      mode_of = rbt_pkg::RBT_DRIVE_B;
    end else begin
      mode_of = rbt_pkg::RBT_DRIVE_A;
    end
  endfunction : mode_of

  // Mux inputs are all flops on clk, so a select change cannot glitch
  always_comb begin
    a_port_bits_o = '0;
    a_port_bits_oe = '0;
    b_port_bits_o = '0;
    b_port_bits_oe = '0;
    for (int s = 0; s < SLICES; s++) begin
      a_port_bits_o[s*SLICE_W +: SLICE_W] = asel_s2_q[s] ?
        b_store_q[s*SLICE_W +: SLICE_W] : b_in_s2_q[s*SLICE_W +: SLICE_W];
      b_port_bits_o[s*SLICE_W +: SLICE_W] = bsel_s2_q[s] ?
        a_store_q[s*SLICE_W +: SLICE_W] : a_in_s2_q[s*SLICE_W +: SLICE_W];
      case (mode_of(den_s2_q[s], dir_s2_q[s]))
        rbt_pkg::RBT_DRIVE_A: begin
          a_port_bits_oe[s*SLICE_W +: SLICE_W] = '1;
        end
        rbt_pkg::RBT_DRIVE_B: begin
          b_port_bits_oe[s*SLICE_W +: SLICE_W] = '1;
        end
        default: begin
          a_port_bits_oe[s*SLICE_W +: SLICE_W] = '0;
          b_port_bits_oe[s*SLICE_W +: SLICE_W] = '0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Capture log
  // ----------------------------------------------------------------
  // Captures never stall; a full buffer drops the entry and flags it
  rbt_stream_if #(.W(LOG_W)) log_in ();
  rbt_stream_if #(.W(LOG_W)) log_out ();

  assign log_in.valid = |{a_rise, b_rise};
  assign log_in.data = {a_rise, b_rise, a_in_s2_q, b_in_s2_q};
  assign log_space = log_in.ready;
  assign log_valid = log_out.valid;
  assign log_data = log_out.data;
  assign log_out.ready = log_ready;

  rbt_buf2 #(
    .W(LOG_W),
    .DEPTH(`RBT_LOG_DEPTH)
  ) u_log_buf (
    .clk(clk),
    .rstn(rstn),
    .in_s(log_in),
    .out_s(log_out)
  );

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      log_overrun_q <= 1'b0;
    end else if (log_in.valid && !log_in.ready) begin
      log_overrun_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  AST_NEVER_BOTH: assert property (~|(a_port_bits_oe & b_port_bits_oe))
    else $error("A and B driven together");

  for (genvar g = 0; g < SLICES; g++) begin : g_chk
    AST_ISOLATE: assert property (
      drive_enable_n[g] |-> ##2
      (a_port_bits_oe[g*SLICE_W +: SLICE_W] == '0 && b_port_bits_oe[g*SLICE_W +: SLICE_W] == '0))
      else $error("Slice not isolated two cycles after disable");
    AST_A_LIVE: assert property (
      (!den_s2_q[g] && !dir_s2_q[g] && !asel_s2_q[g]) |->
      (a_port_bits_oe[g*SLICE_W +: SLICE_W] == '1 &&
       a_port_bits_o[g*SLICE_W +: SLICE_W] == b_in_s2_q[g*SLICE_W +: SLICE_W]))
      else $error("A not driven with live B");
    AST_A_STORED: assert property (
      (!den_s2_q[g] && !dir_s2_q[g] && asel_s2_q[g]) |->
      (a_port_bits_oe[g*SLICE_W +: SLICE_W] == '1 &&
       a_port_bits_o[g*SLICE_W +: SLICE_W] == b_store_q[g*SLICE_W +: SLICE_W]))
      else $error("A not driven with stored B");
    AST_B_LIVE: assert property (
      (!den_s2_q[g] && dir_s2_q[g] && !bsel_s2_q[g]) |->
      (b_port_bits_oe[g*SLICE_W +: SLICE_W] == '1 &&
       b_port_bits_o[g*SLICE_W +: SLICE_W] == a_in_s2_q[g*SLICE_W +: SLICE_W]))
      else $error("B not driven with live A");
    AST_B_STORED: assert property (
      (!den_s2_q[g] && dir_s2_q[g] && bsel_s2_q[g]) |->
      (b_port_bits_oe[g*SLICE_W +: SLICE_W] == '1 &&
       b_port_bits_o[g*SLICE_W +: SLICE_W] == a_store_q[g*SLICE_W +: SLICE_W]))
      else $error("B not driven with stored A");
    AST_CAPTURE_A: assert property (
      $rose(a_capture_clk[g]) |-> ##3
      (a_store_q[g*SLICE_W +: SLICE_W] == $past(a_port_bits_i[g*SLICE_W +: SLICE_W], 3)))
      else $error("A capture missed or wrong");
    AST_CAPTURE_B: assert property (
      $rose(b_capture_clk[g]) |-> ##3
      (b_store_q[g*SLICE_W +: SLICE_W] == $past(b_port_bits_i[g*SLICE_W +: SLICE_W], 3)))
      else $error("B capture missed or wrong");
    AST_HOLD_A: assert property (
      !a_rise[g] |=> $stable(a_store_q[g*SLICE_W +: SLICE_W]))
      else $error("A register changed without edge");
    AST_HOLD_B: assert property (
      !b_rise[g] |=> $stable(b_store_q[g*SLICE_W +: SLICE_W]))
      else $error("B register changed without edge");
    AST_BOTH_STORE: assert property (
      (a_rise[g] && b_rise[g]) |=>
      (a_store_q[g*SLICE_W +: SLICE_W] == $past(a_in_s2_q[g*SLICE_W +: SLICE_W]) &&
       b_store_q[g*SLICE_W +: SLICE_W] == $past(b_in_s2_q[g*SLICE_W +: SLICE_W])))
      else $error("Simultaneous capture lost a side");
    AST_NO_GLITCH: assert property (
      ($stable(den_s2_q[g]) && $stable(dir_s2_q[g]) &&
       $stable(b_in_s2_q[g*SLICE_W +: SLICE_W]) && $stable(b_store_q[g*SLICE_W +: SLICE_W]) &&
       b_store_q[g*SLICE_W +: SLICE_W] == b_in_s2_q[g*SLICE_W +: SLICE_W]) |->
      $stable(a_port_bits_o[g*SLICE_W +: SLICE_W]))
      else $error("A output moved on source switch");
  end

  COV_BOTH_CAPTURE: cover property (a_rise[0] && b_rise[0] && den_s2_q[0]);
  COV_STORED_TO_B: cover property (!den_s2_q[0] && dir_s2_q[0] && bsel_s2_q[0]);
  COV_SLICES_OPPOSED: cover property (a_port_bits_oe[0] && b_port_bits_oe[SLICE_W]);
  COV_LOG_FULL: cover property (log_in.valid && !log_in.ready);

endmodule : rbt_top

/* core/rbt_cfg.svh */
// Constants of the registered bus transceiver
`ifndef RBT_CFG_SVH
`define RBT_CFG_SVH

// ----------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------
`define RBT_SLICE_W 8
`define RBT_SLICES 2

// ----------------------------------------------------------------
// Reset values of the control synchronisers
// ----------------------------------------------------------------
`define RBT_DRIVE_EN_N_RST 1'b1
`define RBT_CTRL_RST 1'b0

// ----------------------------------------------------------------
// Capture log buffer
// ----------------------------------------------------------------
`define RBT_LOG_DEPTH 2

`endif

/* core/rbt_pkg.sv */
// Types of the registered bus transceiver
package rbt_pkg;

  // Output mode of one slice
  typedef enum logic [1:0] {
    RBT_ISOLATE,
    RBT_DRIVE_A,
    RBT_DRIVE_B
  } rbt_mode_e;

endpackage : rbt_pkg

/* core/rbt_stream_if.sv */
// Valid/ready stream between the transceiver and its log buffer
`timescale 1ns/10ps
interface rbt_stream_if #(
  parameter int W = 36
);
  logic valid;
  logic ready;
  logic [W-1:0] data;

  modport src (
    output valid,
    output data,
    input ready
  );
  modport snk (
    input valid,
    input data,
    output ready
  );
endinterface : rbt_stream_if

/* core/rbt_buf2.sv */
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/10ps
`include "rbt_cfg.svh"
module rbt_buf2 #(
  parameter int W = 36,
  parameter int DEPTH = `RBT_LOG_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Filling side
  rbt_stream_if.snk in_s,
  // Draining side
  rbt_stream_if.src out_s
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_q;
  logic [PW-1:0] rd_q;
  logic [PW:0] cnt_q;
  logic push;
  logic pop;

  // ----------------------------------------------------------------
  // Handshake
  // ----------------------------------------------------------------
  assign in_s.ready = (cnt_q != (PW+1)'(DEPTH));
  assign out_s.valid = (cnt_q != '0);
  assign out_s.data = mem_q[rd_q];
  assign push = in_s.valid && in_s.ready;
  assign pop = out_s.valid && out_s.ready;

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction : ptr_inc

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // Data words need no reset; valid comes from the count
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_s.data;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= ptr_inc(wr_q);
      end
      if (pop) begin
        rd_q <= ptr_inc(rd_q);
      end
      cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

endmodule : rbt_buf2

/* sim/rbt_bus_model.sv */
// Partner model: the two parallel buses facing the A and B ports
`timescale 1ns/10ps
module rbt_bus_model (
  // Clock
  input wire logic clk,
  // Bench side
  input wire logic [15:0] a_val,
  input wire logic [15:0] a_en,
  input wire logic [15:0] b_val,
  input wire logic [15:0] b_en,
  // Design side
  input wire logic [15:0] a_o,
  input wire logic [15:0] a_oe,
  input wire logic [15:0] b_o,
  input wire logic [15:0] b_oe,
  output logic [15:0] a_in,
  output logic [15:0] b_in
);
  logic [15:0] a_last_q;
  logic [15:0] b_last_q;

  initial begin
    a_last_q = 16'h0000;
    b_last_q = 16'h0000;
  end

  // Released bits flip each cycle, so a stale level never looks valid
  always_comb begin
    a_in = (a_oe & a_o) | (~a_oe & a_en & a_val) | (~a_oe & ~a_en & ~a_last_q);
    b_in = (b_oe & b_o) | (~b_oe & b_en & b_val) | (~b_oe & ~b_en & ~b_last_q);
  end

  always @(posedge clk) begin
    a_last_q <= a_in;
    b_last_q <= b_in;
  end
endmodule : rbt_bus_model

/* sim/rbt_tb_top.sv */
// Self-checking bench of the registered bus transceiver
`timescale 1ns/10ps
module rbt_tb_top;
  logic clk;
  logic rstn;
  logic [1:0] den_n, dir, a_src, b_src, a_clk, b_clk;
  logic [15:0] a_val, a_en, b_val, b_en, a_in, b_in, a_o, a_oe, b_o, b_oe;
  logic log_valid, log_ready, log_space, log_overrun_q;
  logic [35:0] log_data;
  int bad_count, tests_run, cycles;

  rbt_top u_rbt_top (.clk(clk), .rstn(rstn), .drive_enable_n(den_n), .a_to_b_flow_sel(dir),
    .a_out_source_sel(a_src), .b_out_source_sel(b_src), .a_capture_clk(a_clk),
    .b_capture_clk(b_clk), .a_port_bits_i(a_in), .a_port_bits_o(a_o),
    .a_port_bits_oe(a_oe), .b_port_bits_i(b_in), .b_port_bits_o(b_o),
    .b_port_bits_oe(b_oe), .log_valid(log_valid), .log_ready(log_ready),
    .log_data(log_data), .log_space(log_space), .log_overrun_q(log_overrun_q));

  rbt_bus_model u_rbt_bus_model (.clk(clk), .a_val(a_val), .a_en(a_en), .b_val(b_val),
    .b_en(b_en), .a_o(a_o), .a_oe(a_oe), .b_o(b_o), .b_oe(b_oe), .a_in(a_in), .b_in(b_in));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ------------------------------------------------
  // Tasks
  // ------------------------------------------------
  task close_out;
    if (bad_count == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out

  task chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Pins reach the outputs two edges after sampling; four leaves margin
  task ctl(input logic [1:0] en_n, input logic [1:0] d, input logic [1:0] sa,
    input logic [1:0] sb);
    @(posedge clk);
    den_n <= en_n;
    dir <= d;
    a_src <= sa;
    b_src <= sb;
    repeat (4) @(posedge clk);
    #1;
  endtask : ctl

  task bus(input logic [15:0] av, input logic [15:0] ae, input logic [15:0] bv,
    input logic [15:0] be);
    @(posedge clk);
    a_val <= av;
    a_en <= ae;
    b_val <= bv;
    b_en <= be;
    repeat (4) @(posedge clk);
    #1;
  endtask : bus

  // Capture clocks high two cycles, then low six cycles while waiting for the store
  task cap(input logic [1:0] ma, input logic [1:0] mb);
    @(posedge clk);
    a_clk <= ma;
    b_clk <= mb;
    repeat (2) @(posedge clk);
    a_clk <= 2'b00;
    b_clk <= 2'b00;
    repeat (6) @(posedge clk);
    #1;
  endtask : cap

  // Word is read between edges, then taken at the next rising edge
  task pop(input logic [35:0] exp);
    int n;
    n = 0;
    log_ready <= 1'b1;
    do begin
      @(negedge clk);
      n++;
    end while (log_valid !== 1'b1 && n < 20);
    tests_run++;
    if (log_valid !== 1'b1 || log_data !== exp) begin
      bad_count++;
      $display("wrong value at %0t: log word %h expected %h", $time, log_data, exp);
    end
    @(posedge clk);
  endtask : pop

  // Hang guard, far above the roughly 110 cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      close_out();
    end
  end

  // ------------------------------------------------
  // Main sequence
  // ------------------------------------------------
  initial begin
    bad_count = 0;
    tests_run = 0;
    cycles = 0;
    rstn = 1'b0;
    den_n = 2'b11;
    {dir, a_src, b_src, a_clk, b_clk} = 10'h000;
    {a_val, a_en, b_val, b_en} = {16'hc35a, 16'hffff, 16'h96e1, 16'hffff};
    log_ready = 1'b0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk(a_oe | b_oe, 16'h0000);
    chk({15'h0, log_space}, 16'h0001);
    cap(2'b11, 2'b11);
    bus(16'h0ff0, 16'hffff, 16'h96e1, 16'hff00);
    ctl(2'b10, 2'b11, 2'b00, 2'b11);
    chk(b_oe, 16'h00ff);
    chk(a_oe, 16'h0000);
    chk({8'h00, b_o[7:0]}, 16'h005a);
    ctl(2'b10, 2'b11, 2'b00, 2'b10);
    chk({8'h00, b_o[7:0]}, 16'h00f0);
    cap(2'b01, 2'b00);
    ctl(2'b10, 2'b11, 2'b00, 2'b11);
    chk({8'h00, b_o[7:0]}, 16'h00f0);
    chk({15'h0, log_space}, 16'h0000);
    // Third capture finds the buffer full
    cap(2'b10, 2'b00);
    chk({15'h0, log_overrun_q}, 16'h0001);
    bus(16'h0ff0, 16'hff00, 16'h96e1, 16'hffff);
    ctl(2'b10, 2'b10, 2'b01, 2'b10);
    chk(a_oe, 16'h00ff);
    chk(b_oe, 16'h0000);
    chk({8'h00, a_o[7:0]}, 16'h00e1);
    bus(16'h0ff0, 16'hff00, 16'h9633, 16'hffff);
    ctl(2'b10, 2'b10, 2'b00, 2'b10);
    chk({8'h00, a_o[7:0]}, 16'h0033);
    bus(16'h0ff0, 16'hff00, 16'h9633, 16'h00ff);
    ctl(2'b00, 2'b10, 2'b00, 2'b10);
    chk(a_oe, 16'h00ff);
    chk(b_oe, 16'hff00);
    chk({8'h00, b_o[15:8]}, 16'h000f);
    ctl(2'b11, 2'b10, 2'b00, 2'b10);
    chk(a_oe | b_oe, 16'h0000);
    // Drain the log; the dropped third word must not appear
    @(posedge clk);
    pop({2'b11, 2'b11, 16'hc35a, 16'h96e1});
    pop({2'b01, 2'b00, 16'h0ff0, 16'h96f0});
    repeat (3) @(posedge clk);
    #1;
    chk({14'h0, log_valid, log_space}, 16'h0001);
    chk({15'h0, log_overrun_q}, 16'h0001);
    // Mid-run reset clears the log but must leave the storage alone
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk({14'h0, log_overrun_q, log_space}, 16'h0001);
    chk(a_oe | b_oe, 16'h0000);
    ctl(2'b10, 2'b11, 2'b00, 2'b11);
    chk({8'h00, b_o[7:0]}, 16'h00f0);
    close_out();
  end
endmodule : rbt_tb_top
